// ==== tsn_conv.sv ====
`timescale 1ns/1ps

package tsn_pkg;
  localparam logic [3:0]  ADDR_TYPE_ID     = 4'h9;
  localparam logic [2:0]  ADDR_LOW_DEFAULT = 3'h0;
  localparam logic [4:0]  HS_CODE_PREFIX   = 5'h01;
  localparam logic [3:0]  BYTE_LAST_BIT    = 4'h8;
  localparam int          TEMP_W           = 12;
  localparam logic [11:0] RES_LOW_MASK     = 12'h007;
  localparam logic [3:0]  LSB_PAD          = 4'h0;
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          CONV_TIME_9_US   = 2500;
  localparam int          CONV_CYCLES_9    = CONV_TIME_9_US * 1000 / CLK_PERIOD_NS;
  localparam int          CONV_CNT_W       = 20;

  typedef enum logic [1:0] {
    tsn_res_9  = 2'b00,
    tsn_res_10 = 2'b01,
    tsn_res_11 = 2'b10,
    tsn_res_12 = 2'b11
  } tsn_res_e;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_addr = 2'b01,
    st_wr   = 2'b10,
    st_rd   = 2'b11
  } tsn_state_e;
endpackage : tsn_pkg

module tsn_conv #(
  parameter int unsigned CONV_CYCLES_9 = tsn_pkg::CONV_CYCLES_9,
  parameter int          CNT_W         = tsn_pkg::CONV_CNT_W
) (
  input  wire logic                       i_sys_clk,           // System clock
  input  wire logic                       i_rst_n,             // Async reset, active low
  input  wire logic [1:0]                 i_resolution_select, // Resolution code
  input  wire logic [tsn_pkg::TEMP_W-1:0] i_temp_code,         // Raw sensor code
  output logic      [tsn_pkg::TEMP_W-1:0] o_result,            // Latest result
  output logic                            o_result_load        // Result updated
);
  import tsn_pkg::*;

  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [1:0]        res_cur;
  logic [1:0]        next_res_cur;
  logic [TEMP_W-1:0] next_result;
  logic              next_result_load;

  // Each extra bit doubles the conversion time
  function automatic logic [CNT_W-1:0] conv_len(input logic [1:0] res);
    return CNT_W'(CONV_CYCLES_9) << res;  // see RL11
  endfunction : conv_len

  function automatic logic [TEMP_W-1:0] res_mask(input logic [1:0] res);
    return ~(RES_LOW_MASK >> res);  // see RL10, see RL17
  endfunction : res_mask

  always_comb begin
    next_cnt         = cnt - CNT_W'(1);
    next_res_cur     = res_cur;
    next_result      = o_result;
    next_result_load = 1'b0;
    if (cnt == '0) begin  // see RL8
      next_result      = i_temp_code & res_mask(res_cur);  // see RL13
      next_result_load = 1'b1;
      // New resolution takes effect only at a conversion boundary
      next_res_cur     = i_resolution_select;
      next_cnt         = conv_len(i_resolution_select) - CNT_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt           <= CNT_W'(CONV_CYCLES_9) - CNT_W'(1);
      res_cur       <= tsn_res_9;  // see RL12
      o_result      <= '0;
      o_result_load <= 1'b0;
    end else begin
      cnt           <= next_cnt;
      res_cur       <= next_res_cur;
      o_result      <= next_result;
      o_result_load <= next_result_load;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_load_restart: assert property (o_result_load |-> cnt == conv_len(res_cur) - CNT_W'(1)) // see RL11
    else $error("conversion length does not match resolution");
  // The mask is that of the conversion just ended, not of the one now starting
  a_low_bits_zero: assert property ($rose(o_result_load) |-> (o_result & ~res_mask($past(res_cur))) == '0) // see RL17
    else $error("unused result bits not zero");
  a_result_only_on_load: assert property (!o_result_load |-> $stable(o_result)) // see RL8
    else $error("result changed outside a conversion end");
  c_res12_load: cover property (res_cur == tsn_res_12 && o_result_load);
endmodule : tsn_conv

// ==== tsn_target.sv ====
`timescale 1ns/1ps

// Overview of operation
// RL1: The 7-bit address is 1001 followed by three per-variant fixed low bits.
// RL2: A matching address byte after a Start is acknowledged, a mismatch is not and goes idle.
// RL3: The master enters high speed with a Start then a code byte 00001xxx.
// RL4: The data line stays released in the acknowledge slot of the high-speed code.
// RL5: The high-speed code selects fast filtering and the target goes idle awaiting a Start.
// RL6: High speed holds across repeated Starts and ends at a Stop.
// RL7: The master should chain high-speed transfers with repeated Starts, not Stop then Start.
// RL8: Conversions run back to back and each end loads the result.
// RL9: The result can be read at any time without blocking or corruption.
// RL10: A two-bit field selects 9 to 12 bits, a step of 0.5 down to 0.0625 degrees.
// RL11: Conversion time grows with each extra bit of resolution.
// RL12: After reset the resolution is nine bits.
// RL13: The 12-bit signed result spans -128 to +127 degrees.
// RL14: Data is sampled on the clock rise and driven after the clock fall.
// RL15: An acknowledge holds the data line low for the whole ninth clock.
// RL16: Address bit 0 high means read, low means write.
// RL17: Codes 00 to 11 give 9 to 12 bits and unused low result bits read zero.
module tsn_target #(
  parameter logic [2:0]  TARGET_ADDRESS_LOW_BITS = tsn_pkg::ADDR_LOW_DEFAULT,
  parameter int unsigned CONV_CYCLES_9           = tsn_pkg::CONV_CYCLES_9
) (
  input  wire logic                       i_sys_clk,              // System clock, 10 MHz
  input  wire logic                       i_rst_n,                // Async reset, active low
  input  wire logic                       i_scl,                  // Serial clock pin
  input  wire logic                       i_sda,                  // Serial data pin level
  output logic                            o_sda_out,              // Data drive value, always 0
  output logic                            o_sda_oe,               // Data drive enable
  input  wire logic [1:0]                 i_resolution_select,    // Resolution code
  input  wire logic [tsn_pkg::TEMP_W-1:0] i_temp_code,            // Raw sensor code
  output logic                            o_high_speed_operation, // Fast filter select
  output logic      [tsn_pkg::TEMP_W-1:0] o_temp_result,          // Latest result
  output logic                            o_result_load           // Result updated pulse
);
  import tsn_pkg::*;

  localparam logic [6:0] OWN_ADDR = {ADDR_TYPE_ID, TARGET_ADDRESS_LOW_BITS};  // see RL1

  // Pin synchronisers; the third stage is only for edge detection
  logic scl_m;
  logic scl_s;
  logic scl_d;
  logic sda_m;
  logic sda_s;
  logic sda_d;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  tsn_conv #(
    .CONV_CYCLES_9 (CONV_CYCLES_9),
    .CNT_W         (CONV_CNT_W)
  ) u_conv (
    .i_sys_clk           (i_sys_clk),
    .i_rst_n             (i_rst_n),
    .i_resolution_select (i_resolution_select),
    .i_temp_code         (i_temp_code),
    .o_result            (o_temp_result),
    .o_result_load       (o_result_load)
  );

  tsn_state_e        state;
  tsn_state_e        next_state;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit_cnt;
  logic              ack_slot;
  logic              next_ack_slot;
  logic [7:0]        rx;
  logic [7:0]        next_rx;
  logic [7:0]        tx;
  logic [7:0]        next_tx;
  logic [TEMP_W-1:0] snap;
  logic [TEMP_W-1:0] next_snap;
  logic              byte_sel;
  logic              next_byte_sel;
  logic              master_nack;
  logic              next_master_nack;
  logic              next_sda_oe;
  logic              next_hs;
  logic              hs_code;
  logic              addr_hit;

  function automatic logic [7:0] tx_byte(input logic [TEMP_W-1:0] v, input logic sel);
    return sel ? {v[3:0], LSB_PAD} : v[TEMP_W-1:4];
  endfunction : tx_byte

  assign hs_code  = (rx[7:3] == HS_CODE_PREFIX);  // see RL3
  assign addr_hit = (rx[7:1] == OWN_ADDR);

  always_comb begin
    next_state       = state;
    next_bit_cnt     = bit_cnt;
    next_ack_slot    = ack_slot;
    next_rx          = rx;
    next_tx          = tx;
    next_snap        = snap;
    next_byte_sel    = byte_sel;
    next_master_nack = master_nack;
    next_sda_oe      = o_sda_oe;
    next_hs          = o_high_speed_operation;
    if (stop_det) begin
      next_state  = st_idle;
      next_sda_oe = 1'b0;
      next_hs     = 1'b0;  // see RL6
    end else if (start_det) begin
      // Repeated Start leaves the speed setting alone
      next_state    = st_addr;  // see RL6
      next_bit_cnt  = '0;
      next_ack_slot = 1'b0;
      next_sda_oe   = 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          next_sda_oe = 1'b0;
        end
        st_addr, st_wr: begin
          if (scl_rise && bit_cnt != BYTE_LAST_BIT) begin
            next_rx      = {rx[6:0], sda_s};  // see RL14
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BYTE_LAST_BIT && !ack_slot) begin
            next_ack_slot = 1'b1;
            if (state == st_wr) begin
              next_sda_oe = 1'b1;  // see RL15
            end else if (hs_code) begin
              next_hs    = 1'b1;  // see RL5
              next_state = st_idle;  // see RL4
            end else if (addr_hit) begin
              next_sda_oe = 1'b1;  // see RL2, see RL15
            end else begin
              next_state = st_idle;  // see RL2
            end
          end else if (scl_fall && ack_slot) begin
            next_ack_slot = 1'b0;
            next_bit_cnt  = '0;
            next_sda_oe   = 1'b0;
            if (state == st_addr && rx[0]) begin  // see RL16
              // Freeze the result so a conversion end cannot tear the word
              next_snap     = o_temp_result;  // see RL9
              next_byte_sel = 1'b0;
              next_tx       = tx_byte(o_temp_result, 1'b0);
              next_sda_oe   = ~o_temp_result[TEMP_W-1];  // see RL14
              next_state    = st_rd;
            end else begin
              next_state = st_wr;
            end
          end
        end
        st_rd: begin
          if (bit_cnt != BYTE_LAST_BIT) begin
            if (scl_fall) begin
              next_sda_oe = ~tx[7];  // see RL14
            end else if (scl_rise) begin
              next_tx      = {tx[6:0], 1'b0};
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end else if (scl_fall && !ack_slot) begin
            next_sda_oe   = 1'b0;
            next_ack_slot = 1'b1;
          end else if (scl_rise && ack_slot) begin
            next_master_nack = sda_s;
          end else if (scl_fall && ack_slot) begin
            next_ack_slot = 1'b0;
            if (master_nack) begin
              next_state = st_idle;
            end else begin
              next_bit_cnt  = '0;
              next_byte_sel = ~byte_sel;
              next_tx       = tx_byte(snap, ~byte_sel);
              next_sda_oe   = ~next_tx[7];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state                  <= st_idle;
      bit_cnt                <= '0;
      ack_slot               <= 1'b0;
      rx                     <= '0;
      tx                     <= '0;
      snap                   <= '0;
      byte_sel               <= 1'b0;
      master_nack            <= 1'b0;
      o_sda_oe               <= 1'b0;
      o_sda_out              <= 1'b0;
      o_high_speed_operation <= 1'b0;
    end else begin
      state                  <= next_state;
      bit_cnt                <= next_bit_cnt;
      ack_slot               <= next_ack_slot;
      rx                     <= next_rx;
      tx                     <= next_tx;
      snap                   <= next_snap;
      byte_sel               <= next_byte_sel;
      master_nack            <= next_master_nack;
      o_sda_oe               <= next_sda_oe;
      o_sda_out              <= 1'b0;
      o_high_speed_operation <= next_hs;
    end
  end

  logic addr_decide;
  assign addr_decide = scl_fall && !start_det && !stop_det && state == st_addr
                       && bit_cnt == BYTE_LAST_BIT && !ack_slot;
  // Clock falls that the state machine acts on; a Start or Stop in the same cycle wins
  logic rd_fall;
  logic wr_decide;
  assign rd_fall   = scl_fall && !start_det && !stop_det && state == st_rd;
  assign wr_decide = scl_fall && !start_det && !stop_det && state == st_wr
                     && bit_cnt == BYTE_LAST_BIT && !ack_slot;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_addr_ack_match: assert property (addr_decide && addr_hit && !hs_code |=> o_sda_oe) // see RL2
    else $error("matching address not acknowledged");
  a_addr_miss_idle: assert property (addr_decide && !addr_hit && !hs_code // see RL2
                                     |=> !o_sda_oe && state == st_idle)
    else $error("mismatched address not released to idle");
  a_hs_code_enter: assert property (addr_decide && hs_code // see RL4
                                    |=> (o_high_speed_operation && !o_sda_oe) [*2])
    else $error("high-speed code handled wrongly");
  a_hs_code_idle: assert property (addr_decide && hs_code |=> state == st_idle) // see RL5
    else $error("target not idle after high-speed code");
  a_hs_stop_exit: assert property (stop_det |=> !o_high_speed_operation) // see RL6
    else $error("high speed kept after a Stop");
  a_hs_restart_hold: assert property (start_det && o_high_speed_operation // see RL6
                                      |=> o_high_speed_operation)
    else $error("high speed lost at a repeated Start");
  a_ack_held: assert property (state != st_rd && ack_slot && o_sda_oe && !scl_fall // see RL15
                               && !start_det && !stop_det |=> o_sda_oe)
    else $error("acknowledge released inside the ninth clock");
  a_drive_after_fall: assert property ($changed(o_sda_oe) // see RL14
                                       |-> $past(scl_fall) || $past(start_det)
                                           || $past(stop_det))
    else $error("data drive changed away from a clock fall");
  a_sample_on_rise: assert property ($changed(rx) |-> $past(scl_rise)) // see RL14
    else $error("data sampled away from a clock rise");
  a_read_snap_stable: assert property (state == st_rd && $past(state) == st_rd // see RL9
                                       |-> $stable(snap))
    else $error("read data changed during a transfer");

  // Read checks compare against the snapshot; only a_rd_snap_take compares it with the live result
  a_wr_byte_ack: assert property (wr_decide |=> o_sda_oe) // see RL15
    else $error("written byte not acknowledged");
  a_stop_idle: assert property (stop_det |=> state == st_idle && !o_sda_oe) // see RL6
    else $error("target not idle after a Stop");
  a_idle_silent: assert property (state == st_idle && $past(state) == st_idle // see RL2
                                  |-> !o_sda_oe)
    else $error("data line driven while idle");
  a_hs_only_code: assert property ($rose(o_high_speed_operation) // see RL5
                                   |-> $past(addr_decide) && $past(hs_code))
    else $error("high speed set without the high-speed code");
  a_rd_first_bit: assert property (state == st_rd && $past(state) == st_addr // see RL14
                                   |-> o_sda_oe == !snap[TEMP_W-1])
    else $error("first read bit is not the result sign");
  a_rd_snap_take: assert property (state == st_rd && $past(state) == st_addr // see RL9
                                   |-> snap == $past(o_temp_result))
    else $error("read snapshot differs from the result");
  a_rd_bit_drive: assert property (rd_fall && bit_cnt != BYTE_LAST_BIT // see RL14
                                   |=> o_sda_oe == !$past(tx[7]))
    else $error("read bit not driven from the shift register");
  a_rd_ack_release: assert property (rd_fall && bit_cnt == BYTE_LAST_BIT // see RL14
                                     && !ack_slot |=> !o_sda_oe)
    else $error("data line held in the master acknowledge slot");
  a_rd_nack_idle: assert property (rd_fall && ack_slot && master_nack // see RL16
                                   |=> state == st_idle && !o_sda_oe)
    else $error("read not ended by a master not-acknowledge");

  c_addr_ack: cover property (addr_decide && addr_hit ##1 o_sda_oe);
  c_hs_entry: cover property ($rose(o_high_speed_operation));
  c_read_two: cover property (state == st_rd && byte_sel && bit_cnt == BYTE_LAST_BIT);
  c_read_during_conv: cover property (state == st_rd && o_result_load);
endmodule : tsn_target

// ==== tsn_master.sv ====
`timescale 1ns/1ps

module tsn_master (
  input  wire logic i_sys_clk, // System clock used to pace the bus
  input  wire logic i_sda,     // Resolved data line
  output logic      o_scl,     // Serial clock drive
  output logic      o_sda_rel  // High releases the data line to the pull-up
);
  // Each phase lasts at least the 4-clock minimum the target needs
  localparam int QTR = 4;

  initial begin
    o_scl     = 1'b1;
    o_sda_rel = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick

  // Doubles as repeated Start, which keeps high speed alive between transfers
  task automatic start();
    o_sda_rel = 1'b1;
    tick(QTR);
    o_scl = 1'b1;
    tick(2 * QTR);
    o_sda_rel = 1'b0;
    tick(2 * QTR);
    o_scl = 1'b0;
    tick(QTR);
  endtask : start

  task automatic stop();
    o_sda_rel = 1'b0;
    tick(QTR);
    o_scl = 1'b1;
    tick(2 * QTR);
    o_sda_rel = 1'b1;
    tick(2 * QTR);
  endtask : stop

  // Data only moves while the clock is low; sampled mid-way through the high phase
  task automatic bit_x(input logic b, output logic r);
    o_sda_rel = b;
    tick(QTR);
    o_scl = 1'b1;
    tick(QTR);
    r = i_sda;
    tick(QTR);
    o_scl = 1'b0;
    tick(QTR);
  endtask : bit_x

  // MSB first; the ninth slot is sent as ack_in and read back as ack
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ack_in, ack);
  endtask : xfer
endmodule : tsn_master

// ==== test_temp_sensor_i2c_addr_hs_measure.sv ====
`timescale 1ns/1ps

module test_temp_sensor_i2c_addr_hs_measure;
  import tsn_pkg::*;
  localparam int         CONV9   = 16;
  localparam logic [2:0] ADDR_LO = 3'h5;

  logic        i_sys_clk;
  logic        i_rst_n;
  logic        scl;
  logic        sda_rel;
  logic        sda_out;
  logic        sda_oe;
  logic        hs;
  logic        load;
  logic [1:0]  res;
  logic [11:0] temp_code;
  logic [11:0] temp_result;
  wire logic   sda;
  int          fail_count;
  int          n_tests;

  // Open-drain line with a pull-up: the target's drive value counts only while enabled
  assign sda = (sda_oe ? sda_out : 1'b1) & sda_rel;

  tsn_target #(.TARGET_ADDRESS_LOW_BITS(ADDR_LO), .CONV_CYCLES_9(CONV9)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_resolution_select(res),
    .i_temp_code(temp_code), .o_high_speed_operation(hs),
    .o_temp_result(temp_result), .o_result_load(load));

  tsn_master mst_u (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel));

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      fail_count++;
    end
  endtask : check

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Counts edges from the call up to the next pulse, bounded
  task automatic wait_load(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (load !== 1'b1 && n < 1000);
  endtask : wait_load

  task automatic t_reset();
    int n;
    i_rst_n = 1'b0;
    res     = 2'b11;
    tick(10);
    check(16'({sda_out, sda_oe, hs, load, temp_result}), 16'h0, "outputs in reset");
    i_rst_n = 1'b1;
    // Twelve bits are requested, yet the first conversion must still be nine bits
    wait_load(n);
    check(16'(n), 16'(CONV9), "first conversion length");
    check(16'(temp_result), 16'(temp_code & ~12'h007), "first result");
    $display("test reset done");
  endtask : t_reset

  task automatic t_addr();
    logic [7:0] q;
    logic       a;
    for (int i = 0; i < 8; i++) begin
      mst_u.start();
      mst_u.xfer({ADDR_TYPE_ID, i[2:0], 1'b0}, 1'b1, q, a);
      check(16'(a), 16'(i[2:0] != ADDR_LO), "address ack");
      if (i[2:0] == ADDR_LO) begin
        mst_u.xfer(8'h3c, 1'b1, q, a);
        check(16'(a), 16'h0, "write byte ack");
      end else begin
        // Own address without a fresh Start must be ignored
        mst_u.xfer({ADDR_TYPE_ID, ADDR_LO, 1'b0}, 1'b1, q, a);
        check(16'(a), 16'h1, "idle after mismatch");
      end
      mst_u.stop();
    end
    mst_u.start();
    mst_u.xfer({4'h1, ADDR_LO, 1'b1}, 1'b1, q, a);
    check(16'(a), 16'h1, "wrong type nibble");
    mst_u.stop();
    $display("test address done");
  endtask : t_addr

  task automatic t_hs();
    logic [7:0] q;
    logic       a;
    for (int j = 0; j < 8; j++) begin
      mst_u.start();
      mst_u.xfer({HS_CODE_PREFIX, j[2:0]}, 1'b1, q, a);
      check(16'(a), 16'h1, "code slot released");
      check(16'(hs), 16'h1, "high speed on");
      if (j == 0) begin
        mst_u.xfer({ADDR_TYPE_ID, ADDR_LO, 1'b0}, 1'b1, q, a);
        check(16'(a), 16'h1, "idle after code");
      end
      mst_u.start();
      mst_u.xfer({ADDR_TYPE_ID, ADDR_LO, 1'b0}, 1'b1, q, a);
      check(16'(a), 16'h0, "address after repeated start");
      check(16'(hs), 16'h1, "high speed kept");
      mst_u.stop();
      check(16'(hs), 16'h0, "high speed dropped");
    end
    $display("test high speed done");
  endtask : t_hs

  // A reset in mid-run must drop high speed and restart at nine bits
  task automatic t_rst_mid();
    logic [7:0] q;
    logic       a;
    int         n;
    mst_u.start();
    mst_u.xfer({HS_CODE_PREFIX, 3'h0}, 1'b1, q, a);
    check(16'(hs), 16'h1, "high speed before reset");
    res     = 2'b11;
    i_rst_n = 1'b0;
    tick(2);
    check(16'({sda_out, sda_oe, hs, load, temp_result}), 16'h0, "outputs in mid-run reset");
    i_rst_n = 1'b1;
    wait_load(n);
    check(16'(n), 16'(CONV9), "conversion length after reset");
    check(16'(temp_result), 16'(temp_code & ~12'h007), "result after reset");
    mst_u.stop();
    $display("test mid-run reset done");
  endtask : t_rst_mid

  task automatic t_conv(input logic [1:0] r);
    logic [7:0]  msb;
    logic [7:0]  lsb;
    logic        a;
    int          n;
    logic [11:0] exp;
    res       = r;
    temp_code = 12'hc97 ^ {10'h0, r};
    exp       = temp_code & ~(12'h007 >> r);
    // A new code only applies from the next boundary, so skip two loads
    wait_load(n);
    wait_load(n);
    wait_load(n);
    check(16'(n), 16'(CONV9 << r), "conversion period");
    check(16'(temp_result), 16'(exp), "result value");
    mst_u.start();
    mst_u.xfer({ADDR_TYPE_ID, ADDR_LO, 1'b1}, 1'b1, msb, a);
    check(16'(a), 16'h0, "read address ack");
    mst_u.xfer(8'hff, 1'b0, msb, a);
    mst_u.xfer(8'hff, 1'b1, lsb, a);
    mst_u.stop();
    check({msb, lsb}, {exp, 4'h0}, "read data");
    $display("test conversion %0d done", r);
  endtask : t_conv

  initial begin
    fail_count = 0;
    n_tests    = 0;
    i_rst_n    = 1'b0;
    res        = 2'b11;
    temp_code  = 12'h19b;
    t_reset();
    t_addr();
    t_hs();
    t_rst_mid();
    for (int r = 0; r < 4; r++) begin
      t_conv(r[1:0]);
    end
    give_verdict();
  end

  // Whole run needs roughly 8700 cycles
  initial begin
    tick(60000);
    fail_count++;
    give_verdict();
  end
endmodule : test_temp_sensor_i2c_addr_hs_measure
